// ### prhc_pkg.sv
package prhc_pkg;
	localparam logic [11:0] REF_CTRL_OFF = 12'h01c;
	localparam logic [11:0] HOLD_CTRL_OFF = 12'h01d;
	localparam logic [11:0] STATUS_OFF = 12'h01f;
	localparam logic [11:0] REF_CTRL_ADDR = 12'h070;
	localparam logic [11:0] HOLD_CTRL_ADDR = 12'h074;
	localparam logic [11:0] STATUS_ADDR = 12'h07c;
	localparam logic [7:0] REF_CTRL_RST = 8'h00;
	localparam logic [7:0] HOLD_CTRL_RST = 8'h00;
	localparam int RC_DEGLITCH_OFF = 7;
	localparam int RC_MANUAL_CHOICE = 6;
	localparam int RC_USE_PIN = 5;
	localparam int RC_AUTO = 4;
	localparam int RC_NO_REVERT = 3;
	localparam int RC_SEC_PWR = 2;
	localparam int RC_PRI_PWR = 1;
	localparam int RC_DIFF = 0;
	localparam int HC_STAT_DIS = 4;
	localparam int HC_CMP_EN = 3;
	localparam int HC_HOLD_EN = 2;
	localparam int HC_EXT = 1;
	localparam int HC_HOLD_EN2 = 0;
	localparam int ST_HOLD_ACT = 5;
	localparam int ST_SEC_SEL = 4;
	localparam int ST_SEC_GOOD = 2;
	localparam int ST_PRI_GOOD = 1;
	localparam int ST_LOCK = 0;
	localparam logic [1:0] DEGLITCH_CYC = 2'h3;
	typedef enum logic [1:0] {
		PRHC_ON_PRI = 2'b00,
		PRHC_ON_SEC = 2'b01,
		PRHC_HOLD = 2'b10
	} prhc_state_e;
endpackage

// ### prhc_sync_if.sv
`timescale 1ns/100ps
interface prhc_sync_if;
	logic [4:0] raw;
	logic [4:0] clean;
	modport owner(output raw, input clean);
	modport sync(input raw, output clean);
endinterface

// ### prhc_pin_sync.sv
`timescale 1ns/100ps
module prhc_pin_sync (
	input wire logic clk,
	input wire logic rst_n,
	prhc_sync_if.sync sif
);
	logic [4:0] s1_q, s2_q, s3_q, out_q;
	logic [4:0] s1_d, s2_d, s3_d, out_d;

	// A change is accepted only once the second and third stages agree.
	always_comb begin
		s1_d = sif.raw;
		s2_d = s1_q;
		s3_d = s2_q;
		out_d = out_q;
		for (int i = 0; i < 5; i++) begin
			if (s2_q[i] == s3_q[i]) begin
				out_d[i] = s3_q[i];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= 5'h00;
			s2_q <= 5'h00;
			s3_q <= 5'h00;
			out_q <= 5'h00;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
			out_q <= out_d;
		end
	end

	assign sif.clean = out_q;
endmodule

// ### prhc_top.sv
// Chosen here: the APB slave port.
`timescale 1ns/100ps
// What this block does
// - Bit 7 set bypasses switchover deglitch.
// - Register mode: bit 6 picks secondary reference.
// - Manual: bit 5 chooses register or pin.
// - Bit 4 enables automatic switchover, single-ended only.
// - Bit 3 clear reverts to good primary.
// - Manual single-ended mode: bit 2 powers secondary input.
// - Manual mode: bit 1 powers primary input.
// - Bit 0 selects differential reference mode.
// - Holdover bit 4 disables status readback.
// - Comparator off reads as true.
// - Auto holdover uses comparator for prior lock.
// - Otherwise comparator result goes to monitor pins.
// - Holdover needs bits 2 and 0.
// - Bit 1 hands holdover to external pin.
// - Bit 0 is second holdover enable.
// - Status bit 5 shows holdover active.
// - Status bit 4 shows secondary selected.
module prhc_top (
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic REF_SELECT_PIN,
	input wire logic HOLDOVER_PIN,
	input wire logic PRIMARY_REFERENCE_GOOD,
	input wire logic SECONDARY_REFERENCE_GOOD,
	input wire logic LOCK_DETECT_PIN_HIGH,
	input wire logic PLL_LOCKED,
	output logic SELECT_SECONDARY,
	output logic DEGLITCH_ENABLE,
	output logic PRIMARY_POWER_ON,
	output logic SECONDARY_POWER_ON,
	output logic DIFFERENTIAL_MODE,
	output logic HOLDOVER_ACTIVE,
	output logic REFERENCE_MONITOR_PIN,
	output logic STATUS_PIN
);
	logic [7:0] ref_ctrl_q, ref_ctrl_d;
	logic [7:0] hold_ctrl_q, hold_ctrl_d;
	logic [31:0] rdata_q, rdata_d;
	logic err_q, err_d;
	prhc_pkg::prhc_state_e st_q, st_d;
	logic sel_q, sel_d;
	logic [1:0] dg_cnt_q, dg_cnt_d;
	logic want_sec, auto_mode, hold_en, ext_hold, cmp_val, was_locked;
	logic pin_sel, pin_hold, pri_good, sec_good, ld_high;
	logic access, wr;

	prhc_sync_if sif();

	// All pins from other domains except PLL_LOCKED share one three-stage synchroniser.
	assign sif.raw = {LOCK_DETECT_PIN_HIGH, SECONDARY_REFERENCE_GOOD,
		PRIMARY_REFERENCE_GOOD, HOLDOVER_PIN, REF_SELECT_PIN};

	prhc_pin_sync u_sync (
		.clk(MCLK),
		.rst_n(RSTN),
		.sif(sif)
	);

	assign pin_sel = sif.clean[0];
	assign pin_hold = sif.clean[1];
	assign pri_good = sif.clean[2];
	assign sec_good = sif.clean[3];
	assign ld_high = sif.clean[4];

	function automatic logic [31:0] byte_word(input logic [7:0] b);
		byte_word = {24'h000000, b};
	endfunction

	// Register slave; it answers every access in its first access cycle.
	assign access = PSEL && PENABLE;
	assign wr = access && PWRITE;

	always_comb begin
		ref_ctrl_d = ref_ctrl_q;
		hold_ctrl_d = hold_ctrl_q;
		rdata_d = rdata_q;
		err_d = 1'b0;
		if (PSEL && !PENABLE) begin
			rdata_d = 32'h00000000;
			case (PADDR)
				prhc_pkg::REF_CTRL_ADDR: begin
					rdata_d = byte_word(ref_ctrl_q);
				end
				prhc_pkg::HOLD_CTRL_ADDR: begin
					rdata_d = byte_word(hold_ctrl_q);
				end
				prhc_pkg::STATUS_ADDR: begin
					// Status hides behind zeros while readback is disabled.
					if (!hold_ctrl_q[prhc_pkg::HC_STAT_DIS]) begin
						rdata_d[prhc_pkg::ST_HOLD_ACT] = st_q == prhc_pkg::PRHC_HOLD;
						rdata_d[prhc_pkg::ST_SEC_SEL] = sel_q;
						rdata_d[prhc_pkg::ST_SEC_GOOD] = sec_good;
						rdata_d[prhc_pkg::ST_PRI_GOOD] = pri_good;
						rdata_d[prhc_pkg::ST_LOCK] = PLL_LOCKED;
					end
				end
				default: begin
					err_d = 1'b1;
				end
			endcase
		end else if (access) begin
			err_d = err_q;
		end
		if (wr) begin
			case (PADDR)
				prhc_pkg::REF_CTRL_ADDR: begin
					ref_ctrl_d = PWDATA[7:0];
				end
				prhc_pkg::HOLD_CTRL_ADDR: begin
					hold_ctrl_d = {3'h0, PWDATA[4:0]};
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			ref_ctrl_q <= prhc_pkg::REF_CTRL_RST;
			hold_ctrl_q <= prhc_pkg::HOLD_CTRL_RST;
			rdata_q <= 32'h00000000;
			err_q <= 1'b0;
		end else begin
			ref_ctrl_q <= ref_ctrl_d;
			hold_ctrl_q <= hold_ctrl_d;
			rdata_q <= rdata_d;
			err_q <= err_d;
		end
	end

	assign PRDATA = rdata_q;
	assign PREADY = 1'b1;
	assign PSLVERR = access && err_q;

	// Automatic switching is refused in differential mode.
	assign auto_mode = ref_ctrl_q[prhc_pkg::RC_AUTO] &&
		!ref_ctrl_q[prhc_pkg::RC_DIFF];
	assign hold_en = hold_ctrl_q[prhc_pkg::HC_HOLD_EN] &&
		hold_ctrl_q[prhc_pkg::HC_HOLD_EN2];
	assign ext_hold = hold_ctrl_q[prhc_pkg::HC_EXT];
	assign cmp_val = hold_ctrl_q[prhc_pkg::HC_CMP_EN] ? ld_high : 1'b1;
	assign was_locked = cmp_val;

	always_comb begin
		if (ref_ctrl_q[prhc_pkg::RC_DIFF]) begin
			want_sec = 1'b0;
		end else if (ref_ctrl_q[prhc_pkg::RC_USE_PIN]) begin
			want_sec = pin_sel;
		end else begin
			want_sec = ref_ctrl_q[prhc_pkg::RC_MANUAL_CHOICE];
		end
	end

	// Selection and holdover state machine.
	always_comb begin
		st_d = st_q;
		case (st_q)
			prhc_pkg::PRHC_ON_PRI: begin
				if (hold_en && ext_hold && pin_hold) begin
					st_d = prhc_pkg::PRHC_HOLD;
				end else if (auto_mode && !pri_good && sec_good) begin
					st_d = prhc_pkg::PRHC_ON_SEC;
				end else if (auto_mode && !pri_good && hold_en && !ext_hold &&
					was_locked) begin
					st_d = prhc_pkg::PRHC_HOLD;
				end else if (!auto_mode && want_sec) begin
					st_d = prhc_pkg::PRHC_ON_SEC;
				end
			end
			prhc_pkg::PRHC_ON_SEC: begin
				if (hold_en && ext_hold && pin_hold) begin
					st_d = prhc_pkg::PRHC_HOLD;
				end else if (auto_mode) begin
					if (pri_good && !ref_ctrl_q[prhc_pkg::RC_NO_REVERT]) begin
						st_d = prhc_pkg::PRHC_ON_PRI;
					end else if (!sec_good && !pri_good && hold_en &&
						!ext_hold && was_locked) begin
						st_d = prhc_pkg::PRHC_HOLD;
					end
				end else if (!want_sec) begin
					st_d = prhc_pkg::PRHC_ON_PRI;
				end
			end
			prhc_pkg::PRHC_HOLD: begin
				if (!hold_en) begin
					st_d = prhc_pkg::PRHC_ON_PRI;
				end else if (ext_hold) begin
					if (!pin_hold) begin
						st_d = prhc_pkg::PRHC_ON_PRI;
					end
				end else if (pri_good) begin
					st_d = prhc_pkg::PRHC_ON_PRI;
				end else if (sec_good && auto_mode) begin
					st_d = prhc_pkg::PRHC_ON_SEC;
				end
			end
			default: begin
				st_d = prhc_pkg::PRHC_ON_PRI;
			end
		endcase
	end

	// The deglitch path holds a new choice for a few cycles before it
	// reaches the PLL mux, trading switch latency for a clean edge.
	always_comb begin
		sel_d = sel_q;
		dg_cnt_d = 2'h0;
		if ((st_q == prhc_pkg::PRHC_ON_SEC) != sel_q &&
			st_q != prhc_pkg::PRHC_HOLD) begin
			if (ref_ctrl_q[prhc_pkg::RC_DEGLITCH_OFF]) begin
				sel_d = st_q == prhc_pkg::PRHC_ON_SEC;
			end else if (dg_cnt_q == prhc_pkg::DEGLITCH_CYC) begin
				sel_d = st_q == prhc_pkg::PRHC_ON_SEC;
			end else begin
				dg_cnt_d = 2'(dg_cnt_q + 2'h1);
			end
		end
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			st_q <= prhc_pkg::PRHC_ON_PRI;
			sel_q <= 1'b0;
			dg_cnt_q <= 2'h0;
		end else begin
			st_q <= st_d;
			sel_q <= sel_d;
			dg_cnt_q <= dg_cnt_d;
		end
	end

	assign SELECT_SECONDARY = sel_q;
	assign DEGLITCH_ENABLE = !ref_ctrl_q[prhc_pkg::RC_DEGLITCH_OFF];
	assign DIFFERENTIAL_MODE = ref_ctrl_q[prhc_pkg::RC_DIFF];
	// Automatic mode keeps both inputs alive so either can be judged.
	assign PRIMARY_POWER_ON = auto_mode || ref_ctrl_q[prhc_pkg::RC_PRI_PWR];
	assign SECONDARY_POWER_ON = auto_mode ||
		(ref_ctrl_q[prhc_pkg::RC_SEC_PWR] && !ref_ctrl_q[prhc_pkg::RC_DIFF]);
	assign HOLDOVER_ACTIVE = st_q == prhc_pkg::PRHC_HOLD;
	assign REFERENCE_MONITOR_PIN = (hold_en && !ext_hold) ? 1'b0 : cmp_val;
	assign STATUS_PIN = (hold_en && !ext_hold) ? 1'b0 : cmp_val;
endmodule

// ### prhc_far_model.sv
`timescale 1ns/100ps
module prhc_far_model (
	input wire logic clk,
	input wire logic [5:0] cmd,
	output logic sel_pin,
	output logic hold_pin,
	output logic pri_good,
	output logic sec_good,
	output logic ld_high,
	output logic locked
);
	logic [5:0] pins_q = 6'h0f;
	// Pins are registered from cmd on each rising edge, the same edge the design samples on.
	always @(posedge clk) begin
		pins_q <= cmd;
	end
	assign {sel_pin, hold_pin, pri_good, sec_good, ld_high, locked} = pins_q;
endmodule

// ### prhc_chk_sva.sv
`timescale 1ns/100ps
module prhc_chk (
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic REF_SELECT_PIN,
	input wire logic HOLDOVER_PIN,
	input wire logic SELECT_SECONDARY,
	input wire logic DEGLITCH_ENABLE,
	input wire logic PRIMARY_POWER_ON,
	input wire logic SECONDARY_POWER_ON,
	input wire logic HOLDOVER_ACTIVE,
	input wire logic REFERENCE_MONITOR_PIN
);
	logic [7:0] rc_q;
	logic [7:0] hc_q;
	logic wr;
	assign wr = PSEL && PENABLE && PWRITE;
	// Shadow copies follow the settings from the bus alone.
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			rc_q <= 8'h00;
			hc_q <= 8'h00;
		end else if (wr && PADDR == prhc_pkg::REF_CTRL_ADDR) begin
			rc_q <= PWDATA[7:0];
		end else if (wr && PADDR == prhc_pkg::HOLD_CTRL_ADDR) begin
			hc_q <= PWDATA[7:0];
		end
	end
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RSTN);
	sequence s_pin_path;
		!SELECT_SECONDARY [*2] ##[1:10] SELECT_SECONDARY;
	endsequence
	chk_deglitch_bit:
	assert property (DEGLITCH_ENABLE == !rc_q[7]) else $error("deglitch");
	chk_reg_choice:
	assert property ($changed(rc_q[6]) && rc_q[5:4] == 2'h0 && !rc_q[0]
		|-> ##[1:8] SELECT_SECONDARY == rc_q[6]) else $error("reg choice");
	chk_pin_path:
	assert property ($rose(REF_SELECT_PIN) && rc_q[5:4] == 2'h2 && !rc_q[0]
		&& !SELECT_SECONDARY |-> s_pin_path) else $error("pin choice");
	chk_auto_power:
	assert property (rc_q[4] && !rc_q[0] |-> PRIMARY_POWER_ON
		&& SECONDARY_POWER_ON) else $error("auto power");
	chk_manual_power:
	assert property (!rc_q[4] && !rc_q[0] |-> PRIMARY_POWER_ON == rc_q[1]
		&& SECONDARY_POWER_ON == rc_q[2]) else $error("manual power");
	chk_hold_off:
	assert property ((!(hc_q[2] && hc_q[0])) [*3] |-> !HOLDOVER_ACTIVE)
		else $error("hold off");
	chk_ext_hold:
	assert property ($rose(HOLDOVER_PIN) && hc_q[2:0] == 3'h7
		|-> ##[1:8] HOLDOVER_ACTIVE) else $error("ext hold");
	chk_monitor_idle:
	assert property (!hc_q[3] && !(hc_q[2] && hc_q[0] && !hc_q[1])
		|-> REFERENCE_MONITOR_PIN) else $error("monitor");
endmodule
bind prhc_top prhc_chk chk (.MCLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR,
	.PWDATA, .REF_SELECT_PIN, .HOLDOVER_PIN, .SELECT_SECONDARY,
	.DEGLITCH_ENABLE, .PRIMARY_POWER_ON, .SECONDARY_POWER_ON,
	.HOLDOVER_ACTIVE, .REFERENCE_MONITOR_PIN);

// ### pll_reference_switchover_holdover_ctrl_bench.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module pll_reference_switchover_holdover_ctrl_bench;
	localparam logic [11:0] RA = prhc_pkg::REF_CTRL_ADDR;
	localparam logic [11:0] HA = prhc_pkg::HOLD_CTRL_ADDR;
	logic MCLK = 1'h0;
	logic RSTN = 1'h0;
	logic PSEL = 1'h0;
	logic PENABLE = 1'h0;
	logic PWRITE = 1'h0;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h0;
	logic [5:0] cmd = 6'h0f;
	logic [31:0] PRDATA, r, e;
	logic PREADY, PSLVERR, SELECT_SECONDARY, DEGLITCH_ENABLE;
	logic PRIMARY_POWER_ON, SECONDARY_POWER_ON, DIFFERENTIAL_MODE;
	logic HOLDOVER_ACTIVE, REFERENCE_MONITOR_PIN, STATUS_PIN;
	logic REF_SELECT_PIN, HOLDOVER_PIN, PRIMARY_REFERENCE_GOOD;
	logic SECONDARY_REFERENCE_GOOD, LOCK_DETECT_PIN_HIGH, PLL_LOCKED;
	logic [31:0] exp_q[$];
	int n_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	logic bad_addr;
	assign bad_addr = PADDR != RA && PADDR != HA &&
		PADDR != prhc_pkg::STATUS_ADDR;
	prhc_top uut (.MCLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
		.PRDATA, .PREADY, .PSLVERR, .REF_SELECT_PIN, .HOLDOVER_PIN,
		.PRIMARY_REFERENCE_GOOD, .SECONDARY_REFERENCE_GOOD,
		.LOCK_DETECT_PIN_HIGH, .PLL_LOCKED, .SELECT_SECONDARY,
		.DEGLITCH_ENABLE, .PRIMARY_POWER_ON, .SECONDARY_POWER_ON,
		.DIFFERENTIAL_MODE, .HOLDOVER_ACTIVE, .REFERENCE_MONITOR_PIN,
		.STATUS_PIN);
	prhc_far_model far (.clk(MCLK), .cmd, .sel_pin(REF_SELECT_PIN),
		.hold_pin(HOLDOVER_PIN), .pri_good(PRIMARY_REFERENCE_GOOD),
		.sec_good(SECONDARY_REFERENCE_GOOD),
		.ld_high(LOCK_DETECT_PIN_HIGH), .locked(PLL_LOCKED));
	initial forever #5 MCLK = ~MCLK;
	always @(posedge MCLK) begin
		if (++cyc == 5000) begin
			n_errors++;
			summarize();
		end
		if (PSEL && PENABLE && PREADY && !PWRITE) begin
			e = exp_q.pop_front();
			`CHK("prdata", e, PRDATA)
			`CHK("slverr", bad_addr, PSLVERR)
		end
	end
	task automatic summarize();
		if (n_errors == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		PSEL <= 1'h1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge MCLK);
		PENABLE <= 1'h1;
		do @(posedge MCLK); while (PREADY !== 1'h1);
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
		@(posedge MCLK);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		exp_q.push_back(x);
		xfer(1'h0, a, 32'h0);
	endtask
	// Long enough for the pin synchroniser plus the switchover deglitch.
	task automatic st(input logic [5:0] c, input logic [31:0] x);
		cmd <= c;
		repeat (14) @(posedge MCLK);
		`CHK("select", x[prhc_pkg::ST_SEC_SEL], SELECT_SECONDARY)
		`CHK("holdover", x[prhc_pkg::ST_HOLD_ACT], HOLDOVER_ACTIVE)
		rd(prhc_pkg::STATUS_ADDR, x);
	endtask
	initial begin
		r = $urandom(32'h6787d5a6);
		repeat (12) @(posedge MCLK);
		RSTN <= 1'h1;
		@(posedge MCLK);
		`CHK("deglitch", 1'h1, DEGLITCH_ENABLE)
		`CHK("monitor", 1'h1, REFERENCE_MONITOR_PIN)
		`CHK("status pin", 1'h1, STATUS_PIN)
		rd(RA, 32'h0);
		rd(HA, 32'h0);
		rd(12'h078, 32'h0);
		for (int i = 0; i < 6; i++) begin
			r = $urandom;
			xfer(1'h1, RA, r);
			rd(RA, r & 32'hff);
			`CHK("diff", r[0], DIFFERENTIAL_MODE)
			xfer(1'h1, HA, r);
			rd(HA, r & 32'h1f);
		end
		// Holdover stays off while the settings are reshuffled, as a host
		// must keep it during calibration.
		xfer(1'h1, HA, 32'h0);
		xfer(1'h1, RA, 32'h40);
		st(6'h0f, 32'h17);
		xfer(1'h1, RA, 32'h60);
		st(6'h0f, 32'h07);
		st(6'h2f, 32'h17);
		xfer(1'h1, RA, 32'h10);
		`CHK("power", 2'h3, {PRIMARY_POWER_ON, SECONDARY_POWER_ON})
		st(6'h07, 32'h15);
		st(6'h0f, 32'h07);
		xfer(1'h1, RA, 32'h18);
		st(6'h07, 32'h15);
		st(6'h0f, 32'h17);
		xfer(1'h1, RA, 32'h11);
		st(6'h07, 32'h05);
		// Holdover armed outside automatic mode must not start by itself.
		xfer(1'h1, HA, 32'h05);
		st(6'h0f, 32'h07);
		xfer(1'h1, RA, 32'h10);
		st(6'h01, 32'h21);
		`CHK("monitor", 1'h0, REFERENCE_MONITOR_PIN)
		`CHK("status pin", 1'h0, STATUS_PIN)
		st(6'h0f, 32'h07);
		xfer(1'h1, HA, 32'h0d);
		st(6'h01, 32'h01);
		xfer(1'h1, HA, 32'h04);
		st(6'h03, 32'h01);
		xfer(1'h1, HA, 32'h07);
		st(6'h1f, 32'h27);
		xfer(1'h1, HA, 32'h18);
		st(6'h0d, 32'h0);
		`CHK("monitor", 1'h0, REFERENCE_MONITOR_PIN)
		`CHK("status pin", 1'h0, STATUS_PIN)
		RSTN <= 1'h0;
		@(posedge MCLK);
		RSTN <= 1'h1;
		@(posedge MCLK);
		rd(RA, 32'h0);
		rd(HA, 32'h0);
		summarize();
	end
endmodule
